/* hw/dpi_params.svh */
// Register offsets, field positions and reset values of the process image map
`ifndef DPI_PARAMS_SVH
`define DPI_PARAMS_SVH
`define DPI_OFF_THERM_IN      8'h00
`define DPI_OFF_THERM_OUT     8'h04
`define DPI_OFF_SIXTEEN_IN    8'h08
`define DPI_OFF_SINGLE_IN     8'h0c
`define DPI_OFF_SINGLE_OUT    8'h10
`define DPI_OFF_DUAL_OUT      8'h14
`define DPI_OFF_IMAGE_CFG     8'h18
`define DPI_OFF_PACKED_IN     8'h1c
`define DPI_OFF_PACKED_OUT    8'h20
`define DPI_THERM_STATE_LSB   0
`define DPI_THERM_FAULT_LSB   8
`define DPI_THERM_RSVD_LSB    0
`define DPI_THERM_OFF_LSB     8
`define DPI_SINGLE_CTRL_BIT   0
`define DPI_SINGLE_MAN_BIT    0
`define DPI_DUAL_CH1_BIT      0
`define DPI_DUAL_CH2_BIT      1
`define DPI_RST_OFF_BYTE      8'h00
`define DPI_RST_CTRL_BYTE     8'h00
`define DPI_RST_ANALOG_BYTES  8'h00
`define DPI_RESP_OKAY         2'b00
`define DPI_RESP_SLVERR       2'b10
`endif

/* hw/dpi_pkg.sv */
// Types shared by the process image map modules
package dpi_pkg;
   typedef logic [7:0]  dpi_byte_t;
   typedef logic [15:0] dpi_word_t;
   typedef enum logic [1:0] {DPI_WR_IDLE, DPI_WR_RESP} dpi_wr_state_e;
endpackage : dpi_pkg

/* hw/dpi_sync_if.sv */
// Synchronised field levels and their sampled copies, passed into and out of the sampler
`timescale 1ns/1ps
interface dpi_sync_if;
   logic [7:0]  therm_state;
   logic [7:0]  therm_fault;
   logic [15:0] sixteen_in;
   logic        manual_op;
   modport producer (output therm_state, output therm_fault, output sixteen_in,
                     output manual_op);
   modport consumer (input therm_state, input therm_fault, input sixteen_in,
                     input manual_op);
endinterface : dpi_sync_if

/* hw/dpi_sync.sv */
// Two-flop synchroniser for the field inputs of the map except dual_diag_flag
`timescale 1ns/1ps
module dpi_sync
   import dpi_pkg::*;
   (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  therm_state_pin,
   input  wire logic [7:0]  therm_fault_pin,
   input  wire logic [15:0] sixteen_pin,
   input  wire logic        manual_pin,
   dpi_sync_if.producer     sync
   );
   logic [32:0] stage1;
   logic [32:0] stage2;
   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 33'h0;
         stage2 <= 33'h0;
      end else begin
         stage1 <= {manual_pin, sixteen_pin, therm_fault_pin, therm_state_pin};
         stage2 <= stage1;
      end
   end
   assign sync.therm_state = stage2[7:0];
   assign sync.therm_fault = stage2[15:8];
   assign sync.sixteen_in  = stage2[31:16];
   assign sync.manual_op   = stage2[32];
endmodule : dpi_sync

/* hw/dpi_map.sv */
// Digital I/O process image map with AXI4-Lite register access
`timescale 1ns/1ps
`include "dpi_params.svh"
module dpi_map
   import dpi_pkg::*;
   #(
   parameter int THERM_CH  = 8,   // Channels of the thermistor input module
   parameter int WORD_CH   = 16,  // Channels of the word-wide input module
   parameter int SINGLE_CH = 1,   // Channels of the single output module
   parameter int DUAL_CH   = 2    // Channels of the dual output module
   )
   (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  input_channel_state,
   input  wire logic [7:0]  wire_break_short_flag,
   input  wire logic [15:0] sixteen_channel_in,
   input  wire logic        manual_operation,
   input  wire logic [1:0]  dual_diag_flag,
   output logic [7:0]       channel_switch_off,
   output logic             single_channel_out,
   output logic [1:0]       dual_channel_out
   );

   // Byte packing below is fixed; other channel counts need a new image layout
   if (THERM_CH != 8) begin : g_therm_ch_check
      $error("dpi_map: only eight thermistor channels are supported");
   end
   if (WORD_CH != 16) begin : g_word_ch_check
      $error("dpi_map: only sixteen word channels are supported");
   end
   if (SINGLE_CH != 1) begin : g_single_ch_check
      $error("dpi_map: only one single output channel is supported");
   end
   if (DUAL_CH != 2) begin : g_dual_ch_check
      $error("dpi_map: only two dual output channels are supported");
   end

   // Synchronised field levels
   dpi_sync_if sync_bus ();

   dpi_sync u_sync (
      .clk             (clk),
      .rst_n           (rst_n),
      .therm_state_pin (input_channel_state),
      .therm_fault_pin (wire_break_short_flag),
      .sixteen_pin     (sixteen_channel_in),
      .manual_pin      (manual_operation),
      .sync            (sync_bus.producer)
   );

   // Diagnostic bits of the dual output, synchronised here
   // They skip the sample stage, so they reach the read port one edge sooner
   logic [1:0] diag_s1;
   logic [1:0] diag_s2;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diag_s1 <= 2'h0;
         diag_s2 <= 2'h0;
      end else begin
         diag_s1 <= dual_diag_flag;
         diag_s2 <= diag_s1;
      end
   end

   // Sampled image bytes, refreshed every cycle
   dpi_sync_if img ();
   dpi_sample u_sample (
      .clk   (clk),
      .rst_n (rst_n),
      .raw   (sync_bus.consumer),
      .image (img.producer)
   );

   // Software-written image state
   dpi_byte_t off_byte;
   dpi_byte_t single_ctrl;
   dpi_byte_t dual_ctrl;
   dpi_byte_t analog_in_bytes;
   dpi_byte_t analog_out_bytes;
   logic      rsvd_write_seen;

   // Byte-lane merge with strobes; only listed bits may change
   function automatic dpi_byte_t lane_merge(input dpi_byte_t old_v, input dpi_byte_t new_v,
                                            input logic strb, input dpi_byte_t keep);
      lane_merge = strb ? ((new_v & keep) | (old_v & ~keep)) : old_v;
   endfunction : lane_merge

   // Byte address of a process image byte behind the analog area, rounded to words
   function automatic logic [8:0] packed_base(input dpi_byte_t analog_bytes);
      packed_base = ({1'b0, analog_bytes} + 9'h001) & 9'h1fe;
   endfunction : packed_base

   // Write channel: address and data taken in either order
   dpi_wr_state_e wr_state;
   logic          aw_held;
   logic          w_held;
   logic [7:0]    aw_addr;
   logic [31:0]   w_data;
   logic [3:0]    w_strb;
   logic [1:0]    wr_resp;

   assign s_axi_awready = (wr_state == DPI_WR_IDLE) && !aw_held;
   assign s_axi_wready  = (wr_state == DPI_WR_IDLE) && !w_held;
   assign s_axi_bvalid  = (wr_state == DPI_WR_RESP);
   assign s_axi_bresp   = wr_resp;

   wire        aw_take  = s_axi_awvalid && s_axi_awready;
   wire        w_take   = s_axi_wvalid && s_axi_wready;
   wire        aw_have  = aw_held || aw_take;
   wire        w_have   = w_held || w_take;
   wire [7:0]  wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
   wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;
   wire        wr_fire  = (wr_state == DPI_WR_IDLE) && aw_have && w_have;

   // Write decode
   // Read-only images accept a write and ignore it; unknown offsets get an error
   wire wr_therm  = wr_fire && (wr_addr == `DPI_OFF_THERM_OUT);
   wire wr_single = wr_fire && (wr_addr == `DPI_OFF_SINGLE_OUT);
   wire wr_dual   = wr_fire && (wr_addr == `DPI_OFF_DUAL_OUT);
   wire wr_cfg    = wr_fire && (wr_addr == `DPI_OFF_IMAGE_CFG);
   wire wr_ro     = wr_fire && ((wr_addr == `DPI_OFF_THERM_IN) ||
                    (wr_addr == `DPI_OFF_SIXTEEN_IN) || (wr_addr == `DPI_OFF_SINGLE_IN) ||
                    (wr_addr == `DPI_OFF_PACKED_IN) || (wr_addr == `DPI_OFF_PACKED_OUT));
   wire wr_ok     = wr_therm || wr_single || wr_dual || wr_cfg || wr_ro;

   // Reserved byte zero must be written as zero; nonzero is latched as a flag
   wire rsvd_bad  = wr_therm && wr_strb[0] && (wr_data[7:0] != 8'h00);
   // Clear request for the sticky flag, bit 16 in lane 2 of the config word
   wire rsvd_clear = wr_cfg && wr_strb[2] && wr_data[16];

   // Write state machine; the response stands until bready is seen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_state <= DPI_WR_IDLE;
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         aw_addr  <= 8'h00;
         w_data   <= 32'h0;
         w_strb   <= 4'h0;
         wr_resp  <= `DPI_RESP_OKAY;
      end else begin
         case (wr_state)
            DPI_WR_IDLE: begin
               if (wr_fire) begin
                  wr_state <= DPI_WR_RESP;
                  aw_held  <= 1'b0;
                  w_held   <= 1'b0;
                  wr_resp  <= wr_ok ? `DPI_RESP_OKAY : `DPI_RESP_SLVERR;
               end else begin
                  if (aw_take) begin
                     aw_held <= 1'b1;
                     aw_addr <= s_axi_awaddr;
                  end
                  if (w_take) begin
                     w_held <= 1'b1;
                     w_data <= s_axi_wdata;
                     w_strb <= s_axi_wstrb;
                  end
               end
            end
            DPI_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state <= DPI_WR_IDLE;
               end
            end
            default: wr_state <= DPI_WR_IDLE;
         endcase
      end
   end

   // Output image registers; only defined channel bits are writable
   // Masks drop unused bits, so a write there can never reach a pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         off_byte         <= `DPI_RST_OFF_BYTE;
         single_ctrl      <= `DPI_RST_CTRL_BYTE;
         dual_ctrl        <= `DPI_RST_CTRL_BYTE;
         analog_in_bytes  <= `DPI_RST_ANALOG_BYTES;
         analog_out_bytes <= `DPI_RST_ANALOG_BYTES;
         rsvd_write_seen  <= 1'b0;
      end else begin
         if (wr_therm) begin
            off_byte <= lane_merge(off_byte, wr_data[15:8], wr_strb[1], 8'hff);
         end
         if (wr_single) begin
            single_ctrl <= lane_merge(single_ctrl, wr_data[7:0], wr_strb[0], 8'h01);
         end
         if (wr_dual) begin
            dual_ctrl <= lane_merge(dual_ctrl, wr_data[7:0], wr_strb[0], 8'h03);
         end
         if (wr_cfg) begin
            analog_in_bytes  <= lane_merge(analog_in_bytes, wr_data[7:0], wr_strb[0], 8'hff);
            analog_out_bytes <= lane_merge(analog_out_bytes, wr_data[15:8], wr_strb[1], 8'hff);
         end
         // Sticky, cleared by writing 1 to bit 16; a new bad write wins
         if (rsvd_bad) begin
            rsvd_write_seen <= 1'b1;
         end else if (rsvd_clear) begin
            rsvd_write_seen <= 1'b0;
         end
      end
   end

   // Field outputs straight from image bits, one bit per channel
   assign channel_switch_off = off_byte;
   assign single_channel_out = single_ctrl[`DPI_SINGLE_CTRL_BIT];
   assign dual_channel_out   = {dual_ctrl[`DPI_DUAL_CH2_BIT],
                                dual_ctrl[`DPI_DUAL_CH1_BIT]};

   // Read images, low byte first inside each word
   wire [31:0] rd_therm_in  = {16'h0, img.therm_fault, img.therm_state};
   wire [31:0] rd_therm_out = {16'h0, off_byte, 8'h00};
   wire [31:0] rd_sixteen   = {16'h0, img.sixteen_in};
   wire [31:0] rd_single_in = {24'h0, 7'h0, img.manual_op};
   wire [31:0] rd_single_o  = {24'h0, 7'h0, single_ctrl[0]};

   // Dual diagnostics in bits 9:8, beside the control bits they qualify
   wire [31:0] rd_dual      = {22'h0, diag_s2, 6'h0, dual_ctrl[1:0]};
   // Sticky bit 16 tells software a nonzero reserved byte was written
   wire [31:0] rd_cfg       = {15'h0, rsvd_write_seen, analog_out_bytes, analog_in_bytes};

   // Start of digital bytes behind analog data in each image
   wire [31:0] rd_packed_in = {23'h0, packed_base(analog_in_bytes)};
   wire [31:0] rd_packed_o  = {23'h0, packed_base(analog_out_bytes)};

   // Read channel: one transfer at a time, data registered
   // arready stays low while rvalid stands, so rdata cannot move under the master
   logic rd_busy;
   assign s_axi_arready = !rd_busy;
   assign s_axi_rvalid  = rd_busy;
   wire  ar_take        = s_axi_arvalid && s_axi_arready;

   // Read multiplexer; unmapped offsets return zero with an error response
   logic [31:0] next_rdata;
   logic        next_rerr;
   always_comb begin
      next_rerr = 1'b0;
      case (s_axi_araddr)
         `DPI_OFF_THERM_IN:   next_rdata = rd_therm_in;
         `DPI_OFF_THERM_OUT:  next_rdata = rd_therm_out;
         `DPI_OFF_SIXTEEN_IN: next_rdata = rd_sixteen;
         `DPI_OFF_SINGLE_IN:  next_rdata = rd_single_in;
         `DPI_OFF_SINGLE_OUT: next_rdata = rd_single_o;
         `DPI_OFF_DUAL_OUT:   next_rdata = rd_dual;
         `DPI_OFF_IMAGE_CFG:  next_rdata = rd_cfg;
         `DPI_OFF_PACKED_IN:  next_rdata = rd_packed_in;
         `DPI_OFF_PACKED_OUT: next_rdata = rd_packed_o;
         default: begin
            next_rdata = 32'h0;
            next_rerr  = 1'b1;
         end
      endcase
   end

   // Data and response are taken at the address handshake and then held
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_busy     <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `DPI_RESP_OKAY;
      end else if (ar_take) begin
         rd_busy     <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rerr ? `DPI_RESP_SLVERR : `DPI_RESP_OKAY;
      end else if (s_axi_rready) begin
         rd_busy <= 1'b0;
      end
   end
endmodule : dpi_map

/* hw/dpi_sample.sv */
// Registers the synchronised field levels into the input image
`timescale 1ns/1ps
module dpi_sample
   import dpi_pkg::*;
   (
   input  wire logic     clk,
   input  wire logic     rst_n,
   dpi_sync_if.consumer  raw,
   dpi_sync_if.producer  image
   );
   dpi_byte_t state_q;
   dpi_byte_t fault_q;
   dpi_word_t sixteen_q;
   logic      manual_q;
   // Whole image taken in one edge so bytes of a word stay coherent
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= 8'h00;
         fault_q   <= 8'h00;
         sixteen_q <= 16'h0000;
         manual_q  <= 1'b0;
      end else begin
         state_q   <= raw.therm_state;
         fault_q   <= raw.therm_fault;
         sixteen_q <= raw.sixteen_in;
         manual_q  <= raw.manual_op;
      end
   end
   assign image.therm_state = state_q;
   assign image.therm_fault = fault_q;
   assign image.sixteen_in  = sixteen_q;
   assign image.manual_op   = manual_q;
endmodule : dpi_sample

/* sim/dpi_map_sva.sv */
// Concurrent checks on the register port of the process image map
`timescale 1ns/1ps
module dpi_map_sva (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  channel_switch_off,
   input  wire logic        single_channel_out,
   input  wire logic [1:0]  dual_channel_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Handshake decode; writes are only judged when both halves meet
   logic       wr_go;
   logic       rd_go;
   logic [7:0] lane1;
   logic [1:0] low2;
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign lane1 = s_axi_wdata[15:8];
   assign low2  = s_axi_wdata[1:0];

   chk_switch_off_wr:
      assert property (wr_go && s_axi_awaddr == 8'h04 && s_axi_wstrb[1]
         |=> channel_switch_off == $past(lane1)) else $error("switch-off byte not taken");
   chk_single_out_wr:
      assert property (wr_go && s_axi_awaddr == 8'h10 && s_axi_wstrb[0]
         |=> single_channel_out == $past(low2[0])) else $error("single output not taken");
   chk_dual_out_wr:
      assert property (wr_go && s_axi_awaddr == 8'h14 && s_axi_wstrb[0]
         |=> dual_channel_out == $past(low2)) else $error("dual output not taken");
   chk_outputs_hold:
      assert property (!$rose(s_axi_bvalid) |-> $stable({channel_switch_off, single_channel_out,
         dual_channel_out})) else $error("output moved without a write");
   chk_write_answer:
      assert property (wr_go |=> s_axi_bvalid) else $error("write not answered");
   chk_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
         else $error("write response dropped");
   chk_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
         else $error("read data dropped");
   chk_read_answer:
      assert property (rd_go |=> s_axi_rvalid) else $error("read not answered");
   chk_unmapped_err:
      assert property (rd_go && s_axi_araddr > 8'h20 |=> s_axi_rresp == 2'b10)
         else $error("unmapped read not refused");
   chk_reserved_zero:
      assert property (rd_go && s_axi_araddr == 8'h04
         |=> s_axi_rdata[7:0] == 8'h00 && s_axi_rdata[31:16] == 16'h0000)
         else $error("reserved bits not zero");
   // Main scenarios reached
   cover property (wr_go && s_axi_awaddr == 8'h04);
   cover property (s_axi_rvalid && !s_axi_rready);
   cover property (rd_go && s_axi_araddr > 8'h20);
   cover property (wr_go && s_axi_awaddr == 8'h04 && s_axi_wstrb[0]
      && s_axi_wdata[7:0] != 8'h00);
endmodule : dpi_map_sva

bind dpi_map dpi_map_sva i_sva (.*);

/* sim/dpi_ctrl_model.sv */
// Bus master standing in for the node controller
`timescale 1ns/1ps
module dpi_ctrl_model (
   input  wire logic        clk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   initial {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;

   // Ready comes late at random, so the slave must hold its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (!s_axi_bready) s_axi_bready <= 1'($urandom_range(0, 1));
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      s_axi_awaddr <= ~a;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (!s_axi_rready) s_axi_rready <= 1'($urandom_range(0, 1));
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : dpi_ctrl_model

/* sim/test_digital_io_process_image_map.sv */
// Self-checking bench for the digital I/O process image map
`timescale 1ns/1ps
`define CHK(got, exp) chk(32'(got), 32'(exp))
module test_digital_io_process_image_map;
   import dpi_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, channel_switch_off;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, dual_channel_out;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        single_channel_out;
   logic [7:0]  input_channel_state = '0;
   logic [7:0]  wire_break_short_flag = '0;
   logic [15:0] sixteen_channel_in = '0;
   logic        manual_operation = 1'b0;
   logic [1:0]  dual_diag_flag = '0;
   int          sw, single, dual, ain, aout, seen, error_cnt, checks_done;

   dpi_map i_dut (.*);
   dpi_ctrl_model i_ctrl (.*);

   always #12.5 clk = ~clk;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Reference image built from pins and the written shadow values
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h00: return {16'h0000, wire_break_short_flag, input_channel_state};
         8'h04: return {16'h0000, 8'(sw), 8'h00};
         8'h08: return {16'h0000, sixteen_channel_in};
         8'h0c: return {31'h0, manual_operation};
         8'h10: return {31'h0, 1'(single)};
         8'h14: return {22'h0, dual_diag_flag, 6'h00, 2'(dual)};
         8'h18: return {15'h0, 1'(seen), 8'(aout), 8'(ain)};
         8'h1c: return 32'((ain + 1) & ~1);
         8'h20: return 32'((aout + 1) & ~1);
         default: return 32'h0;
      endcase
   endfunction : exp_rd

   task automatic do_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      logic [10:0] o;
      i_ctrl.wr(a, d, s, r);
      `CHK(r, a > 8'h20 ? 2'b10 : 2'b00);
      if (a == 8'h04 && s[1]) sw = d[15:8];
      if (a == 8'h04 && s[0] && d[7:0] != 8'h00) seen = 1;
      if (a == 8'h10 && s[0]) single = d[0];
      if (a == 8'h14 && s[0]) dual = d[1:0];
      if (a == 8'h18 && s[0]) ain = d[7:0];
      if (a == 8'h18 && s[1]) aout = d[15:8];
      if (a == 8'h18 && s[2] && d[16]) seen = 0;
      o = {channel_switch_off, single_channel_out, dual_channel_out};
      `CHK(o, {8'(sw), 1'(single), 2'(dual)});
   endtask : do_wr

   task automatic do_rd(input logic [7:0] a);
      logic [31:0] d;
      logic [1:0]  r;
      i_ctrl.rd(a, d, r);
      `CHK(r, a > 8'h20 ? 2'b10 : 2'b00);
      if (a <= 8'h20) `CHK(d, exp_rd(a));
   endtask : do_rd

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // Main sequence: reset image, then random pins and writes with random lanes
   initial begin
      void'($urandom(21284));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a <= 'h20; a += 4) do_rd(8'(a));
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         input_channel_state <= 8'($urandom);
         wire_break_short_flag <= 8'($urandom);
         sixteen_channel_in <= 16'($urandom);
         manual_operation <= 1'($urandom);
         dual_diag_flag <= 2'($urandom);
         repeat (4) @(posedge clk);
         do_wr(8'h04, $urandom & 32'hffff_ff00, 4'($urandom));
         do_wr(8'h10, $urandom, 4'($urandom));
         do_wr(8'h14, $urandom, 4'($urandom));
         do_wr(8'h18, {16'h0000, 8'($urandom_range(0, 254)), 8'($urandom_range(0, 254))}, 4'h3);
         do_wr(8'h08, $urandom, 4'hf);
         do_wr(8'h30, $urandom, 4'hf);
         for (int a = 0; a <= 'h24; a += 4) do_rd(8'(a));
      end
      // Misuse of the reserved byte raises the sticky flag; bit 16 clears it
      do_wr(8'h04, 32'($urandom_range(1, 255)), 4'h1);
      do_rd(8'h18);
      do_rd(8'h04);
      do_wr(8'h18, {15'h0, 1'b1, 8'(aout), 8'(ain)}, 4'h7);
      do_rd(8'h18);
      conclude();
   end

   // Whole run needs about a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      conclude();
   end
endmodule : test_digital_io_process_image_map
